// file: core/hpr_read_port.sv
// Read side of the asynchronous 16-bit host port.
// Assumes register contents arrive on csr_rd_data in the same cycle that csr_rd_addr
// changes, and status FIFOs show their head word until popped.
//
// What the document requires
// RULE1: Host waits 135 ns after RX pops.
// RULE2: Host waits 135 ns after TX status pop.
// RULE3: Host spaces drop-counter reads by 180 ns.
// RULE4: Test-register reads have no side effects.
// RULE5: Fewer dummy reads allowed on slow hosts.
// RULE6: Address selects CSR or a FIFO.
// RULE7: Counter value captured at cycle start.
// RULE8: Cycle spans both strobes being low.
// RULE9: Strobe high gap between single reads.
// RULE10: Drive 16-bit data only during cycle.
// RULE11: Burst returns word per address, max 16.
// RULE12: Strobe high gap between bursts.
// RULE13: FIFO select forces RX data reads.
// RULE14: Direct mode keeps A[2:1], drops A[7:3].
// RULE15: FIFO select timed like address lines.
// RULE16: Direct bursts unlimited, one pop each.
// RULE17: Strobe high gap after direct burst.
// RULE18: TX level settles 135 ns after write.
// RULE19: Synchronise pins, pop once per read.
// RULE20: Delay level and drop update notices.
`timescale 1ns/1ps
`default_nettype none
module hpr_read_port
  import hpr_pkg::*;
#(
  parameter int DATA_W     = hpr_pkg::HPR_DATA_W,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  // Host pins
  input  wire logic                      chip_select_low,
  input  wire logic                      read_strobe_low,
  input  wire logic                      fifo_sel,
  input  wire logic [hpr_pkg::HPR_ADDR_W:1] host_addr,
  output logic      [DATA_W-1:0]         host_data_out,
  output var  logic                      host_data_oe_low,
  // Register file side
  output logic      [hpr_pkg::HPR_ADDR_W:1] csr_rd_addr,
  output var  logic                      csr_capture,
  input  wire logic [DATA_W-1:0]         csr_rd_data,
  // Receive data stream in
  input  wire logic [DATA_W-1:0]         rx_data_in,
  input  wire logic                      rx_data_valid,
  output var  logic                      rx_data_ready,
  // Status FIFO heads and pops
  input  wire logic [DATA_W-1:0]         rx_sts_data,
  input  wire logic                      rx_sts_valid,
  output var  logic                      rx_sts_pop,
  input  wire logic [DATA_W-1:0]         tx_sts_data,
  input  wire logic                      tx_sts_valid,
  output var  logic                      tx_sts_pop,
  // Delayed update notices
  output var  logic                      rx_level_update,
  output var  logic                      tx_level_update,
  output var  logic                      drop_count_update
);

  import hpr_pkg::*;

  localparam int AW = HPR_ADDR_W;
  localparam int LVL_W  = $clog2(HPR_LEVEL_DELAY_CYC + 1);
  localparam int DROP_W = $clog2(HPR_DROP_DELAY_CYC + 1);

  // Synchronised pins
  logic          cs_low_s;
  logic          rd_low_s;
  logic          fsel_s;
  logic [AW:1]   addr_s;
  logic          active;
  logic [AW:1]   eff_addr;

  // Read engine
  hpr_state_t    state;
  hpr_kind_t     kind;
  logic [AW:1]   word_addr;
  logic [4:0]    burst_cnt;
  logic          direct;
  logic          word_live;
  logic          word_done;
  logic          addr_moved;
  logic          burst_ok;

  // Receive data buffer drain side
  logic [DATA_W-1:0] rxd_head;
  logic              rxd_valid;
  logic              rxd_pop;

  // Delay counters
  logic [LVL_W-1:0]  rx_lvl_cnt;
  logic [LVL_W-1:0]  tx_lvl_cnt;
  logic [DROP_W-1:0] drop_cnt;
  logic              drop_read;

  // Address decode, used for the first word and every burst step
  function automatic hpr_kind_t decode(input logic [AW:1] a);
    logic [7:0] byte_addr;
    byte_addr = {a, 1'b0};
    if (byte_addr <= HPR_RXD_LAST) begin
      decode = HPR_KIND_RXD;
    end else if (byte_addr == HPR_RXS_OFF) begin
      decode = HPR_KIND_RXS;
    end else if (byte_addr == HPR_TXS_OFF) begin
      decode = HPR_KIND_TXS;
    end else begin
      decode = HPR_KIND_CSR;
    end
  endfunction

  // RULE19: synchronise async pins
  hpr_sync #(
    .W       (3),
    .RST_VAL ({HPR_SYNC_RST, HPR_SYNC_RST, 1'b0})
  ) u_sync_ctl (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({chip_select_low, read_strobe_low, fifo_sel}),
    .sync_out ({cs_low_s, rd_low_s, fsel_s})
  );

  // RULE15: select goes through the strobe synchroniser, same depth as this address path
  hpr_sync #(
    .W       (AW),
    .RST_VAL ('0)
  ) u_sync_addr (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (host_addr),
    .sync_out (addr_s)
  );

  // Receive data path buffer; it only drains on host reads, so it back-pressures the source
  hpr_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rxd_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_data   (rx_data_in),
    .in_valid  (rx_data_valid),
    .in_ready  (rx_data_ready),
    .out_data  (rxd_head),
    .out_valid (rxd_valid),
    .out_ready (rxd_pop)
  );

  // RULE8: both strobes low
  assign active = !cs_low_s && !rd_low_s;

  // RULE13: select forces RX data
  // RULE14: keep A[2:1] only
  assign eff_addr = fsel_s ? (AW'({HPR_DIRECT_MASK[7:1]}) & addr_s) : addr_s;

  // RULE11: new word on address change
  assign addr_moved = (eff_addr != word_addr);
  // RULE16: direct bursts have no limit
  assign burst_ok   = direct || (burst_cnt < 5'(HPR_BURST_MAX));
  // Only a word that reached the bus counts; a FETCH cut short pops nothing
  assign word_done  = word_live && (state == HPR_HOLD) && (!active || addr_moved);

  // Engine state and word bookkeeping
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state     <= HPR_IDLE;
      kind      <= HPR_KIND_CSR;
      word_addr <= '0;
      burst_cnt <= '0;
      direct    <= 1'b0;
      word_live <= 1'b0;
    end else begin
      unique case (state)
        HPR_IDLE: begin
          if (active) begin
            state     <= HPR_FETCH;
            word_addr <= eff_addr;
            kind      <= decode(eff_addr);
            direct    <= fsel_s;
            burst_cnt <= 5'd1;
            word_live <= 1'b1;
          end
        end
        HPR_FETCH: begin
          state <= active ? HPR_HOLD : HPR_IDLE;
        end
        HPR_HOLD: begin
          if (!active) begin
            state     <= HPR_IDLE;
            word_live <= 1'b0;
          end else if (addr_moved) begin
            word_addr <= eff_addr;
            // Beyond the limit the held word stays on the bus; it pops once on this move, then nothing pops
            if (burst_ok && word_live) begin
              state     <= HPR_FETCH;
              kind      <= decode(eff_addr);
              burst_cnt <= direct ? burst_cnt : 5'(burst_cnt + 1'b1);
            end else begin
              word_live <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // RULE7: capture value at cycle start
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      csr_rd_addr <= '0;
      csr_capture <= 1'b0;
    end else begin
      csr_capture <= 1'b0;
      if ((state == HPR_IDLE && active) || (state == HPR_HOLD && active && addr_moved && burst_ok && word_live)) begin
        csr_rd_addr <= eff_addr;
        csr_capture <= (decode(eff_addr) == HPR_KIND_CSR);
      end
    end
  end

  // RULE6: return selected source
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      host_data_out <= HPR_DATA_RST;
    end else if (state == HPR_FETCH) begin
      unique case (kind)
        HPR_KIND_CSR: host_data_out <= csr_rd_data;
        HPR_KIND_RXD: host_data_out <= rxd_valid ? rxd_head : HPR_DATA_RST;
        HPR_KIND_RXS: host_data_out <= rx_sts_valid ? rx_sts_data : HPR_DATA_RST;
        HPR_KIND_TXS: host_data_out <= tx_sts_valid ? tx_sts_data : HPR_DATA_RST;
      endcase
    end
  end

  // RULE10: drive only while active
  // Release trails the pins by the synchroniser delay plus this register, five cycles; the host must respect it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      host_data_oe_low <= 1'b1;
    end else begin
      host_data_oe_low <= !(active && state != HPR_IDLE);
    end
  end

  // RULE19: one pop per finished word
  // Popping at word end, not start, keeps the bus value stable for the whole word
  assign rxd_pop = word_done && (kind == HPR_KIND_RXD) && rxd_valid;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_sts_pop <= 1'b0;
      tx_sts_pop <= 1'b0;
      drop_read  <= 1'b0;
    end else begin
      rx_sts_pop <= word_done && (kind == HPR_KIND_RXS) && rx_sts_valid;
      tx_sts_pop <= word_done && (kind == HPR_KIND_TXS) && tx_sts_valid;
      // RULE4: test register has no effect
      drop_read  <= word_done && (kind == HPR_KIND_CSR) && ({word_addr, 1'b0} == HPR_DROP_OFF);
    end
  end

  // RULE20: delayed RX level notice
  // RULE1: notice within host wait
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_lvl_cnt      <= '0;
      rx_level_update <= 1'b0;
    end else begin
      rx_level_update <= (rx_lvl_cnt == LVL_W'(1));
      if (rxd_pop || rx_sts_pop) begin
        rx_lvl_cnt <= LVL_W'(HPR_LEVEL_DELAY_CYC - 1);
      end else if (rx_lvl_cnt != '0) begin
        rx_lvl_cnt <= LVL_W'(rx_lvl_cnt - 1'b1);
      end
    end
  end

  // RULE2: delayed TX level notice
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_lvl_cnt      <= '0;
      tx_level_update <= 1'b0;
    end else begin
      tx_level_update <= (tx_lvl_cnt == LVL_W'(1));
      if (tx_sts_pop) begin
        tx_lvl_cnt <= LVL_W'(HPR_LEVEL_DELAY_CYC - 1);
      end else if (tx_lvl_cnt != '0) begin
        tx_lvl_cnt <= LVL_W'(tx_lvl_cnt - 1'b1);
      end
    end
  end

  // RULE3: drop counter settle delay
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      drop_cnt          <= '0;
      drop_count_update <= 1'b0;
    end else begin
      drop_count_update <= (drop_cnt == DROP_W'(1));
      if (drop_read) begin
        drop_cnt <= DROP_W'(HPR_DROP_DELAY_CYC - 1);
      end else if (drop_cnt != '0) begin
        drop_cnt <= DROP_W'(drop_cnt - 1'b1);
      end
    end
  end

endmodule
`default_nettype wire

// file: shared/hpr_pkg.sv
// Constants and types shared by the host read port and its helpers.
// Assumes a single 250 MHz core clock; all times are converted here.
package hpr_pkg;

  // Core clock period
  localparam int HPR_CLK_PERIOD_NS = 4;

  // Host data and address widths
  localparam int HPR_DATA_W = 16;
  localparam int HPR_ADDR_W = 7;

  // Byte addresses seen on the host address pins
  localparam logic [7:0] HPR_RXD_LAST    = 8'h1f;
  localparam logic [7:0] HPR_RXS_OFF     = 8'h40;
  localparam logic [7:0] HPR_TXS_OFF     = 8'h48;
  localparam logic [7:0] HPR_DROP_OFF    = 8'ha4;
  localparam logic [7:0] HPR_DIRECT_MASK = 8'h06;

  // Burst length limit for address-decoded bursts
  localparam int HPR_BURST_MAX = 16;

  // Settle times after a side-effect read, in ns and in cycles (longest time: round down)
  localparam int HPR_LEVEL_DELAY_NS = 135;
  localparam int HPR_DROP_DELAY_NS  = 180;
  localparam int HPR_LEVEL_DELAY_CYC =
    (HPR_LEVEL_DELAY_NS / HPR_CLK_PERIOD_NS) < 1 ? 1 : (HPR_LEVEL_DELAY_NS / HPR_CLK_PERIOD_NS);
  localparam int HPR_DROP_DELAY_CYC =
    (HPR_DROP_DELAY_NS / HPR_CLK_PERIOD_NS) < 1 ? 1 : (HPR_DROP_DELAY_NS / HPR_CLK_PERIOD_NS);

  // Reset values
  localparam logic [HPR_DATA_W-1:0] HPR_DATA_RST = 16'h0000;
  localparam logic                  HPR_SYNC_RST = 1'b1;

  // Read engine states
  typedef enum logic [1:0] {
    HPR_IDLE,
    HPR_FETCH,
    HPR_HOLD
  } hpr_state_t;

  // Target of one word read
  typedef enum logic [1:0] {
    HPR_KIND_CSR,
    HPR_KIND_RXD,
    HPR_KIND_RXS,
    HPR_KIND_TXS
  } hpr_kind_t;

endpackage

// file: core/hpr_sync.sv
// Three-stage synchroniser for a bundle of asynchronous pins.
// Assumes the bundle is quasi-static around each change; the output moves
// only when stages two and three agree on the whole vector.
`timescale 1ns/1ps
`default_nettype none
module hpr_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // Asynchronous input and clean output
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Whole-vector agreement keeps a skewed address from being seen half-changed
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_out <= RST_VAL;
    end else if (stage2 == stage3) begin
      sync_out <= stage3;
    end
  end

endmodule
`default_nettype wire

// file: core/hpr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; in_ready and out_valid are registered.
`timescale 1ns/1ps
`default_nettype none
module hpr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             do_push;
  logic             do_pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign do_push  = in_valid && in_ready;
  assign do_pop   = out_ready && out_valid;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (do_push && !do_pop) begin
      next_count = CW'(count + 1'b1);
    end else if (do_pop && !do_push) begin
      next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (do_push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (do_pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      count     <= next_count;
      in_ready  <= (next_count != CW'(DEPTH));
      out_valid <= (next_count != '0);
    end
  end

endmodule
`default_nettype wire

// file: dv/hpr_read_port_monitor.sv
// Checker for the host read port, bound to its top module.
// Assumes host pins idle high at reset release.
`timescale 1ns/1ps
`default_nettype none
module hpr_read_port_monitor
  import hpr_pkg::*;
#(
  parameter int DATA_W = hpr_pkg::HPR_DATA_W
) (
  // Clock and reset
  input wire logic                         ref_clk,
  input wire logic                         sys_rst,
  // Host pins
  input wire logic                         chip_select_low,
  input wire logic                         read_strobe_low,
  input wire logic [hpr_pkg::HPR_ADDR_W:1] host_addr,
  input wire logic [DATA_W-1:0]            host_data_out,
  input wire logic                         host_data_oe_low,
  // Side outputs
  input wire logic                         csr_capture,
  input wire logic                         rx_sts_valid,
  input wire logic                         rx_sts_pop,
  input wire logic                         tx_sts_valid,
  input wire logic                         tx_sts_pop,
  input wire logic                         tx_level_update
);
  logic [hpr_pkg::HPR_ADDR_W:1] addr_q;
  logic [3:0]                   addr_age;
  logic [6:0]                   tx_age;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Saturating ages keep long idle stretches quiet
  always_ff @(posedge ref_clk) begin
    addr_q <= host_addr;
    if (sys_rst || host_addr != addr_q) addr_age <= 4'h0;
    else if (addr_age != 4'hf) addr_age <= addr_age + 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) tx_age <= 7'h7f;
    else if (tx_sts_pop) tx_age <= 7'h01;
    else if (tx_age != 7'h7f) tx_age <= tx_age + 7'h01;
  end

  sequence s_fetch;
    ##1 !csr_capture ##2 !host_data_oe_low;
  endsequence
  property p_oe_start;
    $fell(host_data_oe_low) |-> $past(!chip_select_low && !read_strobe_low, 3);
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("bus driven outside a cycle");
  property p_release;
    (chip_select_low || read_strobe_low) [*7] |-> host_data_oe_low;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_fetch;
    csr_capture |-> s_fetch;
  endproperty
  a_fetch: assert property (p_fetch) else $error("capture not followed by drive");
  property p_hold;
    !host_data_oe_low && $past(!host_data_oe_low) && addr_age >= 4'ha |-> $stable(host_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved in cycle");
  property p_rx_pop;
    rx_sts_pop |-> rx_sts_valid && $rose(host_data_oe_low) ##1 !rx_sts_pop;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("rx status pop misplaced");
  property p_tx_pop;
    tx_sts_pop |-> tx_sts_valid && $rose(host_data_oe_low) ##1 !tx_sts_pop;
  endproperty
  a_tx_pop: assert property (p_tx_pop) else $error("tx status pop misplaced");
  property p_tx_notice;
    tx_level_update |-> tx_age == 7'h21;
  endproperty
  a_tx_notice: assert property (p_tx_notice) else $error("tx level notice early or late");
  property p_tx_due;
    tx_age == 7'h21 |-> tx_level_update;
  endproperty
  a_tx_due: assert property (p_tx_due) else $error("tx level notice missing");
endmodule

bind hpr_read_port hpr_read_port_monitor #(.DATA_W(DATA_W)) hpr_read_port_monitor_i (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .chip_select_low(chip_select_low),
  .read_strobe_low(read_strobe_low),
  .host_addr(host_addr),
  .host_data_out(host_data_out),
  .host_data_oe_low(host_data_oe_low),
  .csr_capture(csr_capture),
  .rx_sts_valid(rx_sts_valid),
  .rx_sts_pop(rx_sts_pop),
  .tx_sts_valid(tx_sts_valid),
  .tx_sts_pop(tx_sts_pop),
  .tx_level_update(tx_level_update)
);
`default_nettype wire

// file: dv/hpr_host_model.sv
// Host bus master driving the asynchronous read pins.
// Assumes the bench calls rd one at a time and checks hung afterwards.
`timescale 1ns/1ps
`default_nettype none
module hpr_host_model
  import hpr_pkg::*;
(
  // Clock
  input wire logic                           ref_clk,
  // Pins driven
  output var logic                           chip_select_low,
  output var logic                           read_strobe_low,
  output var logic                           fifo_sel,
  output var logic [hpr_pkg::HPR_ADDR_W:1]   host_addr,
  // Read data
  input wire logic [hpr_pkg::HPR_DATA_W-1:0] host_data_out,
  input wire logic                           host_data_oe_low
);
  logic [hpr_pkg::HPR_DATA_W-1:0] got [$];
  logic                           hung;

  initial begin
    chip_select_low = 1'b1;
    read_strobe_low = 1'b1;
    fifo_sel = 1'b0;
    host_addr = '0;
    hung = 1'b0;
  end

  // no writes, no level or drop reads follow
  task automatic rd(input logic [7:0] a, input int n, input logic fs, input logic [1:0] how);
    int k;
    got.delete();
    @(posedge ref_clk);
    #1;
    fifo_sel = fs;
    host_addr = a[7:1];
    chip_select_low = 1'b0;
    read_strobe_low = 1'b0;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (host_data_oe_low !== 1'b0 && k < 40) begin
        @(posedge ref_clk);
        #1;
        k++;
      end
      hung = hung | (k == 40);
      repeat (12) @(posedge ref_clk);
      #1;
      got.push_back(host_data_out);
      if (i < n - 1) host_addr = host_addr + 7'h01;
    end
    chip_select_low = (how != 2'd2);
    read_strobe_low = (how != 2'd1);
    repeat (6) @(posedge ref_clk);
    #1;
    chip_select_low = 1'b1;
    read_strobe_low = 1'b1;
    host_addr = ~host_addr;
    fifo_sel = ~fs;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// file: dv/hpr_read_port_tb.sv
// Self-checking bench for the host read port.
// Models a register file answering in the same cycle as csr_rd_addr.
`timescale 1ns/1ps
`default_nettype none
module hpr_read_port_tb;
  import hpr_pkg::*;
  logic                  ref_clk, sys_rst, chip_select_low, read_strobe_low, fifo_sel;
  logic [HPR_ADDR_W:1]   host_addr, csr_rd_addr;
  logic [HPR_DATA_W-1:0] host_data_out, csr_rd_data, rx_data_in, rx_sts_data, tx_sts_data;
  logic                  host_data_oe_low, csr_capture, rx_data_valid, rx_data_ready;
  logic                  rx_sts_valid, rx_sts_pop, tx_sts_valid, tx_sts_pop;
  logic                  rx_level_update, tx_level_update, drop_count_update;
  logic [15:0]           exp_q [$];
  logic [7:0]            a;
  int                    n_errors, check_count, seed;
  logic                  oe_q;
  int                    rx_age = 1000;
  int                    drop_age = 1000;

  assign csr_rd_data = {4'ha, 1'b0, csr_rd_addr, 4'h5};

  hpr_read_port hpr_read_port_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .chip_select_low(chip_select_low), .read_strobe_low(read_strobe_low), .fifo_sel(fifo_sel),
    .host_addr(host_addr), .host_data_out(host_data_out), .host_data_oe_low(host_data_oe_low),
    .csr_rd_addr(csr_rd_addr), .csr_capture(csr_capture), .csr_rd_data(csr_rd_data),
    .rx_data_in(rx_data_in), .rx_data_valid(rx_data_valid), .rx_data_ready(rx_data_ready),
    .rx_sts_data(rx_sts_data), .rx_sts_valid(rx_sts_valid), .rx_sts_pop(rx_sts_pop),
    .tx_sts_data(tx_sts_data), .tx_sts_valid(tx_sts_valid), .tx_sts_pop(tx_sts_pop),
    .rx_level_update(rx_level_update), .tx_level_update(tx_level_update),
    .drop_count_update(drop_count_update));
  hpr_host_model hpr_host_model_i (.ref_clk(ref_clk), .chip_select_low(chip_select_low),
    .read_strobe_low(read_strobe_low), .fifo_sel(fifo_sel), .host_addr(host_addr),
    .host_data_out(host_data_out), .host_data_oe_low(host_data_oe_low));

  function automatic logic [15:0] csr_exp(input logic [7:0] b);
    return {4'ha, 1'b0, b[7:1], 4'h5};
  endfunction

  task automatic close_out();
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Valid stays up between words so back-to-back pushes never double-drive it
  task automatic push(input logic [15:0] w);
    int k;
    rx_data_in = w;
    rx_data_valid = 1'b1;
    exp_q.push_back(w);
    k = 0;
    while (rx_data_ready !== 1'b1 && k < 50) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k == 50) begin
      n_errors++;
      close_out();
    end
    @(posedge ref_clk);
    #1;
  endtask

  task automatic host_rd(input logic [7:0] b, input int n, input logic fs);
    hpr_host_model_i.rd(b, n, fs, 2'($random(seed)));
    if (hpr_host_model_i.hung) begin
      n_errors++;
      close_out();
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Notice delays counted from the status pop and from the end of the drop-counter read
  always @(negedge ref_clk) begin
    rx_age = (rx_sts_pop === 1'b1) ? 0 : rx_age + 1;
    drop_age = (host_data_oe_low === 1'b1 && oe_q === 1'b0 && csr_rd_addr == HPR_DROP_OFF[7:1]) ? 0 : drop_age + 1;
    oe_q = host_data_oe_low;
    if (rx_age == HPR_LEVEL_DELAY_CYC) chk({15'h0000, rx_level_update}, 16'h0001);
    if (drop_age == HPR_DROP_DELAY_CYC) chk({15'h0000, drop_count_update}, 16'h0001);
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    close_out();
  end

  initial begin
    seed = 32'h58ce;
    n_errors = 0;
    check_count = 0;
    sys_rst = 1'b1;
    rx_data_in = '0;
    rx_data_valid = 1'b0;
    rx_sts_data = '0;
    rx_sts_valid = 1'b0;
    tx_sts_data = '0;
    tx_sts_valid = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    chk({8'h00, host_data_oe_low, rx_sts_pop, tx_sts_pop, csr_capture, rx_level_update,
         tx_level_update, drop_count_update, rx_data_ready}, 16'h0080);
    sys_rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 4; i++) push(16'($random(seed)));
    rx_data_valid = 1'b0;
    chk({15'h0000, rx_data_ready}, 16'h0000);
    host_rd(8'($random(seed)) & 8'h1e, 1, 1'b0);
    chk(hpr_host_model_i.got[0], exp_q.pop_front());
    host_rd(8'($random(seed)), 1, 1'b1);
    chk(hpr_host_model_i.got[0], exp_q.pop_front());
    host_rd(8'($random(seed)), 2, 1'b1);
    chk(hpr_host_model_i.got[0], exp_q.pop_front());
    chk(hpr_host_model_i.got[1], exp_q.pop_front());
    host_rd(8'($random(seed)), 1, 1'b1);
    chk(hpr_host_model_i.got[0], 16'h0000);
    rx_sts_data = 16'($random(seed));
    rx_sts_valid = 1'b1;
    host_rd(8'h40, 1, 1'b0);
    chk(hpr_host_model_i.got[0], rx_sts_data);
    rx_sts_valid = 1'b0;
    tx_sts_data = 16'($random(seed));
    tx_sts_valid = 1'b1;
    host_rd(8'h48, 1, 1'b0);
    chk(hpr_host_model_i.got[0], tx_sts_data);
    tx_sts_valid = 1'b0;
    repeat (40) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'ha4 : (8'h50 | (8'($random(seed)) & 8'h2e));
      host_rd(a, 1, 1'b0);
      chk(hpr_host_model_i.got[0], csr_exp(a));
    end
    // Seventeenth address is past the limit, so the last word repeats
    host_rd(8'h50, 17, 1'b0);
    for (int i = 0; i < 17; i++) begin
      chk(hpr_host_model_i.got[i], csr_exp(8'h50 + 8'((i > 15 ? 15 : i) * 2)));
    end
    close_out();
  end
endmodule
`default_nettype wire
